//--- pfsl_pkg.sv
// Constants and carrier types for the port function select and latch block
package pfsl_pkg;

    localparam logic [15:0] PFSL_ADDR_ROUTE   = 16'hFF20;
    localparam logic [15:0] PFSL_ADDR_ANALOG  = 16'hFF8F;
    localparam logic [15:0] PFSL_ADDR_SEG_TWO = 16'hFFB5;
    localparam logic [15:0] PFSL_ADDR_SEG_GRP = 16'hFFB6;
    localparam logic [15:0] PFSL_ADDR_PORT    = 16'hFF02;

    localparam logic [7:0]  PFSL_RST_ROUTE    = 8'h00;
    localparam logic [7:0]  PFSL_RST_ANALOG   = 8'h08;
    localparam logic [7:0]  PFSL_RST_SEG      = 8'h00;
    localparam logic [7:0]  PFSL_RST_LATCH    = 8'h00;

    localparam logic [7:0]  PFSL_MASK_ROUTE   = 8'h08;
    localparam logic [7:0]  PFSL_MASK_ANALOG  = 8'h0F;
    localparam logic [7:0]  PFSL_MASK_SEG_GRP = 8'h6D;
    localparam logic [7:0]  PFSL_MASK_ALL     = 8'hFF;

    localparam int          PFSL_TX_ROUTE_BIT = 3;
    localparam logic [3:0]  PFSL_CODE_MAX     = 4'h8;
    localparam int          PFSL_SEG_GRP_N    = 5;
    localparam int          PFSL_GRP_BIT [PFSL_SEG_GRP_N] = '{0, 2, 3, 5, 6};

    typedef enum logic [1:0]
    {
        PFSL_OP_WRITE,
        PFSL_OP_READ,
        PFSL_OP_RMW_AND,
        PFSL_OP_RMW_OR
    } pfsl_op_type;

    typedef struct packed
    {
        logic        req;
        pfsl_op_type op;
        logic        bit_op;
        logic [2:0]  bit_idx;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pfsl_cpu_type;

    typedef struct packed
    {
        logic [7:0] route;
        logic [3:0] analog_code;
        logic [7:0] seg_two;
        logic [7:0] seg_grp;
        logic [7:0] latch;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] rdata;
        logic       rvalid;
        logic       wait_req;
        logic       err;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] seg_en;
        logic [7:0] digital;
        logic [4:0] grp_seg;
        logic       shared_out;
    } pfsl_state_type;

endpackage

//--- pfsl_top.sv
// Pin function select registers and group-two port latch logic
`timescale 1ns/1ps
module pfsl_top
    import pfsl_pkg::*;
(
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire pfsl_cpu_type CPU,
    input  wire logic [7:0]   DIRECTION,
    input  wire logic [7:0]   PIN_IN,
    input  wire logic         CSI_OUT,
    input  wire logic         UART_TX,
    output logic [7:0]        RDATA,
    output logic              RVALID,
    output logic              CPU_WAIT,
    output logic              CODE_ERR,
    output logic [7:0]        PIN_OUT,
    output logic [7:0]        PIN_OE,
    output logic [7:0]        SEG_EN,
    output logic [7:0]        DIGITAL_EN,
    output logic [4:0]        GROUP_SEG_EN,
    output logic              SHARED_PIN_OUT
);

    pfsl_state_type s_q;
    pfsl_state_type s_d;

    // Merge a single-bit request into a full byte image of the old value
    function automatic logic [7:0] merge_bit(
        input logic [7:0] old_val,
        input logic       bit_op,
        input logic [2:0] idx,
        input logic [7:0] wdata
    );
        logic [7:0] v;
        v = wdata;
        if (bit_op)
        begin
            v = old_val;
            v[idx] = wdata[0];
        end
        return v;
    endfunction

    // Apply the operation to the source byte image: the old register value, or the port view for the port address
    function automatic logic [7:0] apply_op(
        input pfsl_op_type op,
        input logic [7:0]  src,
        input logic [7:0]  wdata
    );
        logic [7:0] v;
        v = wdata;
        if (op == PFSL_OP_RMW_AND)
            v = src & wdata;
        else if (op == PFSL_OP_RMW_OR)
            v = src | wdata;
        return v;
    endfunction

    // Thermometer mask: lowest k pins digital
    function automatic logic [7:0] digital_mask(input logic [3:0] k);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++)
            if (4'(i) < k)
                m[i] = 1'b1;
        return m;
    endfunction

    logic [7:0] reg_old;
    logic [7:0] reg_mask;
    logic [7:0] port_view;
    logic [7:0] sel_img;
    logic [7:0] port_img;
    logic [7:0] new_val;
    logic       hit_route;
    logic       hit_analog;
    logic       hit_two;
    logic       hit_grp;
    logic       hit_port;

    always_comb
    begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.wait_req = 1'b0;
        s_d.pin_s1 = PIN_IN;
        s_d.pin_s2 = s_q.pin_s1;

        hit_route  = CPU.addr == PFSL_ADDR_ROUTE;
        hit_analog = CPU.addr == PFSL_ADDR_ANALOG;
        hit_two    = CPU.addr == PFSL_ADDR_SEG_TWO;
        hit_grp    = CPU.addr == PFSL_ADDR_SEG_GRP;
        hit_port   = CPU.addr == PFSL_ADDR_PORT;

        reg_old  = 8'h00;
        reg_mask = 8'h00;
        if (hit_route)
        begin
            reg_old  = s_q.route;
            reg_mask = PFSL_MASK_ROUTE;
        end
        else if (hit_analog)
        begin
            reg_old  = {4'h0, s_q.analog_code};
            reg_mask = PFSL_MASK_ANALOG;
        end
        else if (hit_two)
        begin
            reg_old  = s_q.seg_two;
            reg_mask = PFSL_MASK_ALL;
        end
        else if (hit_grp)
        begin
            reg_old  = s_q.seg_grp;
            reg_mask = PFSL_MASK_SEG_GRP;
        end

        // Output pins show the latch, input pins the synchronised level
        port_view = (s_q.latch & ~DIRECTION) | (s_q.pin_s2 & DIRECTION);

        sel_img  = apply_op(CPU.op, reg_old, merge_bit(reg_old, CPU.bit_op, CPU.bit_idx,
                                                       CPU.wdata));
        // Whole byte is rewritten even for a one-bit op, so input-pin latch bits
        // pick up pin levels; mixed ports must expect this
        port_img = apply_op(CPU.op, port_view, merge_bit(port_view, CPU.bit_op, CPU.bit_idx,
                                                         CPU.wdata));
        new_val  = sel_img & reg_mask;

        if (CPU.req)
        begin
            if (CPU.op == PFSL_OP_READ)
            begin
                s_d.rvalid = 1'b1;
                s_d.rdata  = hit_port ? port_view : reg_old & reg_mask;
                if (CPU.bit_op)
                    s_d.rdata = {7'h00, s_d.rdata[CPU.bit_idx]};
            end
            else
            begin
                if (hit_route)
                    s_d.route = new_val;
                if (hit_two)
                    s_d.seg_two = new_val;
                if (hit_grp)
                    s_d.seg_grp = new_val;
                if (hit_analog)
                begin
                    s_d.analog_code = new_val[3:0];
                    s_d.wait_req = 1'b1;
                end
                if (hit_port)
                    s_d.latch = port_img;
                if (CPU.op != PFSL_OP_WRITE)
                begin
                    s_d.rvalid = 1'b1;
                    s_d.rdata  = hit_port ? port_view : reg_old & reg_mask;
                end
            end
        end

        // Prohibited codes treated as all-analog and flagged
        s_d.err     = s_d.analog_code > PFSL_CODE_MAX;
        s_d.digital = s_d.err ? 8'h00 : digital_mask(s_d.analog_code);
        s_d.seg_en  = s_d.seg_two;
        s_d.digital = s_d.digital & ~s_d.seg_two;
        for (int g = 0; g < PFSL_SEG_GRP_N; g++)
            s_d.grp_seg[g] = s_d.seg_grp[PFSL_GRP_BIT[g]];
        // Buffer on only for output-mode digital pins not taken by segments
        s_d.pin_oe  = ~DIRECTION & ~s_d.seg_two & s_d.digital;
        s_d.pin_out = s_d.latch;
        s_d.shared_out = s_d.route[PFSL_TX_ROUTE_BIT] ? UART_TX : CSI_OUT;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            s_q <= '0;
            s_q.route       <= PFSL_RST_ROUTE;
            s_q.seg_two     <= PFSL_RST_SEG;
            s_q.seg_grp     <= PFSL_RST_SEG;
            s_q.analog_code <= PFSL_RST_ANALOG[3:0];
            s_q.digital     <= 8'hFF;
            s_q.latch       <= PFSL_RST_LATCH;
        end
        else
            s_q <= s_d;
    end

    assign RDATA          = s_q.rdata;
    assign RVALID         = s_q.rvalid;
    assign CPU_WAIT       = s_q.wait_req;
    assign CODE_ERR       = s_q.err;
    assign PIN_OUT        = s_q.pin_out;
    assign PIN_OE         = s_q.pin_oe;
    assign SEG_EN         = s_q.seg_en;
    assign DIGITAL_EN     = s_q.digital;
    assign GROUP_SEG_EN   = s_q.grp_seg;
    assign SHARED_PIN_OUT = s_q.shared_out;

endmodule

//--- pfsl_properties.sv
// Concurrent checks on the port function select block ports
`timescale 1ns/1ps
module pfsl_props
    import pfsl_pkg::*;
(
    input wire logic         CLK,
    input wire logic         RST,
    input wire pfsl_cpu_type CPU,
    input wire logic [7:0]   DIRECTION,
    input wire logic [7:0]   RDATA,
    input wire logic         RVALID,
    input wire logic         CPU_WAIT,
    input wire logic         CODE_ERR,
    input wire logic [7:0]   PIN_OUT,
    input wire logic [7:0]   PIN_OE,
    input wire logic [7:0]   SEG_EN,
    input wire logic [7:0]   DIGITAL_EN,
    input wire logic [4:0]   GROUP_SEG_EN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Full-byte writes only; bit ops touch a single field
    wire wr = CPU.req && !CPU.bit_op && CPU.op == PFSL_OP_WRITE;
    wire rd = CPU.req && CPU.op == PFSL_OP_READ;
    wire an = wr && CPU.addr == PFSL_ADDR_ANALOG;

    read_answer_a: assert property (rd |=> RVALID)
        else $error("read not answered");
    analog_wait_a: assert property (an |=> CPU_WAIT)
        else $error("no wait after analog write");
    // Derived outputs land on the same edge as the field and hold, so looking two edges on is safe
    seg_two_a: assert property (
        wr && CPU.addr == PFSL_ADDR_SEG_TWO |=> ##1 SEG_EN == $past(CPU.wdata, 2))
        else $error("segment select mismatch");
    group_seg_a: assert property (
        wr && CPU.addr == PFSL_ADDR_SEG_GRP |=> ##1
        GROUP_SEG_EN == {$past(CPU.wdata[6], 2), $past(CPU.wdata[5], 2), $past(CPU.wdata[3], 2),
        $past(CPU.wdata[2], 2), $past(CPU.wdata[0], 2)})
        else $error("group select mismatch");
    code_ok_a: assert property (
        an && CPU.wdata[3:0] <= 4'h8 |=> ##1 !CODE_ERR &&
        DIGITAL_EN == (8'((9'h001 << $past(CPU.wdata[3:0], 2)) - 9'h001) & ~SEG_EN))
        else $error("digital enable wrong for code");
    code_bad_a: assert property (
        an && CPU.wdata[3:0] > 4'h8 |=> ##1 CODE_ERR && DIGITAL_EN == 8'h00)
        else $error("prohibited code not flagged");
    drive_gate_a: assert property ((PIN_OE & ($past(DIRECTION) | SEG_EN | ~DIGITAL_EN)) == 8'h00)
        else $error("pin driven while not allowed");
    latch_hold_a: assert property (
        !(CPU.req && CPU.addr == PFSL_ADDR_PORT && CPU.op != PFSL_OP_READ)
        |=> $stable(PIN_OUT))
        else $error("latch changed without write");
    latch_read_a: assert property (
        rd && !CPU.bit_op && CPU.addr == PFSL_ADDR_PORT && DIRECTION == 8'h00
        |=> RDATA == $past(PIN_OUT))
        else $error("output mode read not latch");

    cover property (an ##1 CPU_WAIT);
    cover property (CODE_ERR);
    cover property (rd && CPU.addr == PFSL_ADDR_PORT ##1 RVALID);
endmodule

//--- tb_top.sv
// Directed register and port latch tests for the function select block
`timescale 1ns/1ps
module tb_top
    import pfsl_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    pfsl_cpu_type cpu = '0;
    logic [7:0]   dir = 8'h00;
    logic [7:0]   pin = 8'h3C;
    logic         csi = 1'b1;
    logic         utx = 1'b0;
    logic [7:0]   rdata, pout, oe, seg, dig, got;
    logic [4:0]   grp;
    logic         rvalid, cwait, err, shared;
    int           bad_count = 0;
    int           checked = 0;
    logic [15:0]  ra [4] = '{PFSL_ADDR_ROUTE, PFSL_ADDR_ANALOG, PFSL_ADDR_SEG_TWO, PFSL_ADDR_SEG_GRP};
    logic [7:0]   rv [4] = '{8'h00, 8'h08, 8'h00, 8'h00};
    logic [7:0]   mk [4] = '{8'h08, 8'h0F, 8'hFF, 8'h6D};

    always #4 clk = ~clk;

    pfsl_top i_dut (.CLK(clk), .RST(rst), .CPU(cpu), .DIRECTION(dir), .PIN_IN(pin),
        .CSI_OUT(csi), .UART_TX(utx), .RDATA(rdata), .RVALID(rvalid), .CPU_WAIT(cwait),
        .CODE_ERR(err), .PIN_OUT(pout), .PIN_OE(oe), .SEG_EN(seg), .DIGITAL_EN(dig),
        .GROUP_SEG_EN(grp), .SHARED_PIN_OUT(shared));

    // One access; read data taken one edge on, then outputs allowed to settle
    task automatic acc(input pfsl_op_type op, input logic [15:0] a, input logic [7:0] d,
                       input logic b = 1'b0, input logic [2:0] i = 3'h0);
        @(posedge clk);
        #1;
        cpu = '{1'b1, op, b, i, a, d};
        @(posedge clk);
        #1;
        cpu.req = 1'b0;
        got = rdata;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wrap_up;
        $display("Counts: %0d checked, %0d bad", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int n = 0; n < 4; n++)
        begin
            acc(PFSL_OP_READ, ra[n], 8'h00);
            chk(got, rv[n]);
            acc(PFSL_OP_WRITE, ra[n], 8'hFF);
            acc(PFSL_OP_READ, ra[n], 8'h00);
            chk(got, mk[n]);
            acc(PFSL_OP_WRITE, ra[n], 8'h00, 1'b1, 3'h3);
            acc(PFSL_OP_READ, ra[n], 8'h00);
            chk(got, mk[n] & 8'hF7);
            acc(PFSL_OP_WRITE, ra[n], rv[n]);
        end
        acc(PFSL_OP_READ, 16'hFF00, 8'h00);
        chk(got, 8'h00);
        $display("test registers done");
        acc(PFSL_OP_WRITE, PFSL_ADDR_SEG_GRP, 8'h24);
        chk(8'(grp), 8'h0A);
        acc(PFSL_OP_WRITE, PFSL_ADDR_ROUTE, 8'h08);
        chk(8'(shared), 8'h00);
        acc(PFSL_OP_WRITE, PFSL_ADDR_ROUTE, 8'h00);
        chk(8'(shared), 8'h01);
        for (int k = 0; k <= 9; k++)
        begin
            acc(PFSL_OP_WRITE, PFSL_ADDR_ANALOG, 8'(k));
            chk(dig, k > 8 ? 8'h00 : 8'((16'h0001 << k) - 16'h0001));
            chk(8'(err), 8'(k > 8));
        end
        acc(PFSL_OP_WRITE, PFSL_ADDR_SEG_TWO, 8'h0F);
        acc(PFSL_OP_WRITE, PFSL_ADDR_ANALOG, 8'h08);
        chk(seg, 8'h0F);
        chk(dig, 8'hF0);
        chk(oe, 8'hF0);
        acc(PFSL_OP_WRITE, PFSL_ADDR_SEG_TWO, 8'h00);
        $display("test functions done");
        acc(PFSL_OP_WRITE, PFSL_ADDR_PORT, 8'hA5);
        chk(pout, 8'hA5);
        chk(oe, 8'hFF);
        acc(PFSL_OP_READ, PFSL_ADDR_PORT, 8'h00);
        chk(got, 8'hA5);
        acc(PFSL_OP_RMW_OR, PFSL_ADDR_PORT, 8'h02);
        chk(pout, 8'hA7);
        dir = 8'hF0;
        acc(PFSL_OP_READ, PFSL_ADDR_PORT, 8'h00);
        chk(got, 8'h37);
        chk(pout, 8'hA7);
        chk(oe, 8'h0F);
        dir = 8'hFF;
        acc(PFSL_OP_RMW_AND, PFSL_ADDR_PORT, 8'hF0);
        chk(pout, 8'h30);
        chk(oe, 8'h00);
        dir = 8'hF0;
        acc(PFSL_OP_WRITE, PFSL_ADDR_PORT, 8'h01, 1'b1, 3'h0);
        chk(pout, 8'h31);
        $display("test port done");
        wrap_up();
    end

    // Whole sequence needs under two microseconds
    initial
    begin
        #20000;
        bad_count++;
        wrap_up();
    end
endmodule

bind pfsl_top pfsl_props i_props (.*);
